// *** hw/hp_pkg.sv ***
// shared constants and types for the host register port pair
package hp_pkg;
   localparam int          HP_AW          = 7;
   localparam int          HP_DW          = 8;
   localparam int          HP_NDEC        = 8;
   localparam int          HP_NSCSI       = 4;
   // register select codes
   localparam logic [6:0]  HP_A_DEC_STAT  = 7'h00;
   localparam logic [6:0]  HP_A_DEC_MASK  = 7'h01;
   localparam logic [6:0]  HP_A_SCSI_STAT = 7'h10;
   localparam logic [6:0]  HP_A_SCSI_CTRL = 7'h11;
   localparam logic [6:0]  HP_A_CLK_CFG   = 7'h20;
   localparam logic [6:0]  HP_A_BUF_DATA  = 7'h30;
   // field positions and reset values
   localparam int          HP_B_SCSI_EN   = 7;
   localparam int          HP_B_MCK_DIV2  = 0;
   localparam int          HP_B_MCK_STOP  = 1;
   localparam int          HP_B_DBL_FREQ  = 2;
   localparam logic [7:0]  HP_RST_REG     = 8'h00;
   localparam logic [7:0]  HP_ALL_ONES    = 8'hff;
   // timing
   localparam int          HP_CLK_NS      = 4;
   localparam int          HP_RESET_NS    = 1000;
   localparam int          HP_RESET_CYC   =
      (HP_RESET_NS + HP_CLK_NS - 1) / HP_CLK_NS;
   localparam int          HP_SETUP_CYC   = 1;
   localparam int          HP_STROBE_CYC  = 3;
   localparam int          HP_HOLD_CYC    = 1;
   localparam int          HP_CNT_W       = 9;

   typedef enum logic [2:0] {
      HP_ST_RESET  = 3'b000,
      HP_ST_IDLE   = 3'b001,
      HP_ST_SETUP  = 3'b010,
      HP_ST_STROBE = 3'b011,
      HP_ST_HOLD   = 3'b100
   } hp_state_e;
endpackage

// *** hw/hp_link_if.sv ***
// pin-level link between microcontroller and device register port
`timescale 1ns/1ns
interface hp_link_if;
   logic       host_select;
   logic       select_polarity_pin;
   logic       host_read_n;
   logic       host_write_n;
   logic [6:0] reg_select_bus;
   logic       chip_reset_n;
   logic [7:0] host_data_h_o;
   logic       host_data_h_oe;
   logic [7:0] host_data_d_o;
   logic       host_data_d_oe;
   logic       host_wait_n_oe;
   logic       decoder_irq_n_oe;
   logic       scsi_irq_n_oe;
   // resolved wire levels, pull-ups when nobody drives
   logic [7:0] host_data_bus;
   logic       host_wait_n;
   logic       decoder_irq_n;
   logic       scsi_irq_n;

   assign host_data_bus = host_data_d_oe ? host_data_d_o :
                          host_data_h_oe ? host_data_h_o : 8'hff;
   assign host_wait_n   = ~host_wait_n_oe;
   assign decoder_irq_n = ~decoder_irq_n_oe;
   assign scsi_irq_n    = ~scsi_irq_n_oe;

   modport dev (
      input  host_select, select_polarity_pin, host_read_n, host_write_n,
      input  reg_select_bus, chip_reset_n, host_data_bus,
      output host_data_d_o, host_data_d_oe, host_wait_n_oe,
      output decoder_irq_n_oe, scsi_irq_n_oe
   );
   modport host (
      output host_select, select_polarity_pin, host_read_n, host_write_n,
      output reg_select_bus, chip_reset_n, host_data_h_o, host_data_h_oe,
      input  host_data_bus, host_wait_n, decoder_irq_n, scsi_irq_n
   );
endinterface

// *** hw/hp_dev_end.sv ***
// device end: register port, interrupts, wait, clock selection
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
// How it works
// - polarity pin high means select active low
// - seven select lines choose the register
// - read strobe reads, write strobe writes
// - eight-bit data bus, pulled high when idle
// - wait held low until buffer access completes
// - decoder events interrupt through maskable register
// - scsi interrupt only when control bit 7 set
// - interrupt pins only pull low, else released
// - reset pin low holds all state reset except the oscillator and scsi event synchronisers
// - host holds reset low at least 1 us
// - aux select picks scsi clock source
// - scsi side may run unrelated, rising edges only
// - double frequency input halved for even duty
// - master clock out: full, halved or stopped
module hp_dev_end
   import hp_pkg::*;
(
   // clock and reset
   input  wire logic                ref_clk,
   input  wire logic                rst_b,
   // host link
   hp_link_if.dev                   lnk,
   // oscillators and derived clocks
   input  wire logic                main_osc_in,
   input  wire logic                aux_osc_in,
   input  wire logic                aux_osc_select,
   output logic                     master_clock_out,
   output logic                     dec_clk_tick,
   output logic                     scsi_clk_tick,
   // interrupt sources
   input  wire logic [HP_NDEC-1:0]  dec_event,
   input  wire logic [HP_NSCSI-1:0] scsi_event_tgl,
   // buffer ram access
   output logic                     buf_req,
   output logic                     buf_we,
   output logic [HP_DW-1:0]         buf_wdata,
   input  wire logic                buf_ack,
   input  wire logic [HP_DW-1:0]    buf_rdata
);
   logic                sel;
   logic                rd_act;
   logic                wr_act;
   logic                rd_q;
   logic                wr_q;
   logic                rd_start;
   logic                wr_start;
   logic                buf_hit;
   logic [HP_DW-1:0]    rd_mux;
   logic [HP_DW-1:0]    rd_data_q;
   logic [HP_NDEC-1:0]  dec_stat_q;
   logic [HP_NDEC-1:0]  dec_mask_q;
   logic [HP_NSCSI-1:0] scsi_stat_q;
   logic [HP_DW-1:0]    scsi_ctrl_q;
   logic [HP_DW-1:0]    clk_cfg_q;
   logic                pend_q;
   logic                pend_we_q;
   logic [HP_DW-1:0]    pend_wdata_q;
   logic [HP_NSCSI-1:0] ev_s1_q;
   logic [HP_NSCSI-1:0] ev_s2_q;
   logic [HP_NSCSI-1:0] ev_s3_q;
   logic [HP_NSCSI-1:0] scsi_pulse;
   logic [2:0]          main_q;
   logic [2:0]          aux_q;
   logic                main_rise;
   logic                aux_rise;
   logic                half_q;
   logic                mck_q;
   logic                dec_tick_q;
   logic                scsi_tick_q;

   // strobe qualification
   assign sel = lnk.select_polarity_pin ? ~lnk.host_select
                                        : lnk.host_select;
   assign rd_act   = sel & ~lnk.host_read_n;
   assign wr_act   = sel & ~lnk.host_write_n & ~rd_act;
   assign rd_start = rd_act & ~rd_q;
   assign wr_start = wr_act & ~wr_q;
   assign buf_hit  = (lnk.reg_select_bus == HP_A_BUF_DATA);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
      end else if (!lnk.chip_reset_n) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         rd_q <= rd_act;
         wr_q <= wr_act;
      end
   end

   // read decode
   always_comb begin
      rd_mux = HP_RST_REG;
      unique case (lnk.reg_select_bus)
         HP_A_DEC_STAT:  rd_mux = dec_stat_q;
         HP_A_DEC_MASK:  rd_mux = dec_mask_q;
         HP_A_SCSI_STAT: rd_mux = {{(HP_DW-HP_NSCSI){1'b0}}, scsi_stat_q};
         HP_A_SCSI_CTRL: rd_mux = scsi_ctrl_q;
         HP_A_CLK_CFG:   rd_mux = clk_cfg_q;
         default:        rd_mux = HP_RST_REG;
      endcase
   end

   // read latch, also loaded from buffer ram on completion
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_q <= HP_ALL_ONES;
      end else if (!lnk.chip_reset_n) begin
         rd_data_q <= HP_ALL_ONES;
      end else if (pend_q && buf_ack && !pend_we_q) begin
         rd_data_q <= buf_rdata;
      end else if (rd_start) begin
         rd_data_q <= rd_mux;
      end
   end

   assign lnk.host_data_d_o  = rd_data_q;
   assign lnk.host_data_d_oe = rd_act;

   // control registers
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dec_mask_q  <= HP_RST_REG;
         scsi_ctrl_q <= HP_RST_REG;
         clk_cfg_q   <= HP_RST_REG;
      end else if (!lnk.chip_reset_n) begin
         dec_mask_q  <= HP_RST_REG;
         scsi_ctrl_q <= HP_RST_REG;
         clk_cfg_q   <= HP_RST_REG;
      end else if (wr_start) begin
         unique case (lnk.reg_select_bus)
            HP_A_DEC_MASK:  dec_mask_q  <= lnk.host_data_bus;
            HP_A_SCSI_CTRL: scsi_ctrl_q <= lnk.host_data_bus;
            HP_A_CLK_CFG:   clk_cfg_q   <= lnk.host_data_bus;
            default:        dec_mask_q  <= dec_mask_q;
         endcase
      end
   end

   // sticky status, read clears, a new event wins over the clear
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dec_stat_q  <= '0;
         scsi_stat_q <= '0;
      end else if (!lnk.chip_reset_n) begin
         dec_stat_q  <= '0;
         scsi_stat_q <= '0;
      end else begin
         if (rd_start && lnk.reg_select_bus == HP_A_DEC_STAT) begin
            dec_stat_q <= dec_event;
         end else begin
            dec_stat_q <= dec_stat_q | dec_event;
         end
         if (rd_start && lnk.reg_select_bus == HP_A_SCSI_STAT) begin
            scsi_stat_q <= scsi_pulse;
         end else begin
            scsi_stat_q <= scsi_stat_q | scsi_pulse;
         end
      end
   end

   // open-drain interrupts, pull low only while asserted
   assign lnk.decoder_irq_n_oe = |(dec_stat_q & dec_mask_q);
   assign lnk.scsi_irq_n_oe    = scsi_ctrl_q[HP_B_SCSI_EN] &
      |(scsi_stat_q & scsi_ctrl_q[HP_NSCSI-1:0]);

   // scsi-domain events arrive as toggles
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ev_s1_q <= '0;
         ev_s2_q <= '0;
         ev_s3_q <= '0;
      end else begin
         ev_s1_q <= scsi_event_tgl;
         ev_s2_q <= ev_s1_q;
         ev_s3_q <= ev_s2_q;
      end
   end
   assign scsi_pulse = ev_s2_q ^ ev_s3_q;

   // buffer ram access holds wait until the ram side acknowledges
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_q       <= 1'b0;
         pend_we_q    <= 1'b0;
         pend_wdata_q <= HP_RST_REG;
      end else if (!lnk.chip_reset_n) begin
         pend_q       <= 1'b0;
         pend_we_q    <= 1'b0;
         pend_wdata_q <= HP_RST_REG;
      end else if (pend_q) begin
         pend_q <= ~buf_ack;
      end else if ((rd_start || wr_start) && buf_hit) begin
         pend_q       <= 1'b1;
         pend_we_q    <= wr_start;
         pend_wdata_q <= lnk.host_data_bus;
      end
   end

   assign lnk.host_wait_n_oe = pend_q |
      ((rd_start | wr_start) & buf_hit);
   assign buf_req   = pend_q;
   assign buf_we    = pend_we_q;
   assign buf_wdata = pend_wdata_q;

   // oscillator sampling; aux is unrelated so it is synchronised
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         main_q <= '0;
         aux_q  <= '0;
      end else begin
         main_q <= {main_q[1:0], main_osc_in};
         aux_q  <= {aux_q[1:0], aux_osc_in};
      end
   end
   assign main_rise = main_q[1] & ~main_q[2];
   assign aux_rise  = aux_q[1] & ~aux_q[2];

   // clock ticks, master clock output
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         half_q      <= 1'b0;
         mck_q       <= 1'b0;
         dec_tick_q  <= 1'b0;
         scsi_tick_q <= 1'b0;
      end else if (!lnk.chip_reset_n) begin
         half_q      <= 1'b0;
         mck_q       <= 1'b0;
         dec_tick_q  <= 1'b0;
         scsi_tick_q <= 1'b0;
      end else begin
         if (main_rise) begin
            half_q <= ~half_q;
         end
         dec_tick_q <= main_rise &
            (~clk_cfg_q[HP_B_DBL_FREQ] | half_q);
         scsi_tick_q <= aux_osc_select ? aux_rise : main_rise;
         if (clk_cfg_q[HP_B_MCK_STOP]) begin
            mck_q <= 1'b0;
         end else if (clk_cfg_q[HP_B_MCK_DIV2]) begin
            mck_q <= mck_q ^ main_rise;
         end else begin
            mck_q <= main_q[1];
         end
      end
   end

   assign master_clock_out = mck_q;
   assign dec_clk_tick     = dec_tick_q;
   assign scsi_clk_tick    = scsi_tick_q;
endmodule

// *** hw/hp_host_end.sv ***
// microcontroller end: reset release and strobed register cycles
`timescale 1ns/1ns
module hp_host_end
   import hp_pkg::*;
#(
   parameter logic SEL_ACTIVE_LOW = 1'b1
)
(
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   // device link
   hp_link_if.host               lnk,
   // command port
   input  wire logic [HP_AW-1:0] cmd_addr,
   input  wire logic [HP_DW-1:0] cmd_wdata,
   input  wire logic             cmd_wr,
   input  wire logic             cmd_rd,
   output logic                  cmd_busy,
   output logic                  cmd_done,
   output logic [HP_DW-1:0]      cmd_rdata,
   // status
   output logic                  chip_ready,
   output logic                  dec_irq,
   output logic                  scsi_irq
);
   hp_state_e             st_q;
   logic [HP_CNT_W-1:0]   cnt_q;
   logic                  we_q;
   logic [HP_AW-1:0]      addr_q;
   logic [HP_DW-1:0]      wdata_q;
   logic [HP_DW-1:0]      rdata_q;
   logic                  done_q;
   logic                  irq_q;
   logic                  sirq_q;
   logic                  sel;
   logic                  strobe;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q    <= HP_ST_RESET;
         cnt_q   <= '0;
         we_q    <= 1'b0;
         addr_q  <= '0;
         wdata_q <= HP_RST_REG;
         rdata_q <= HP_RST_REG;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         unique case (st_q)
            HP_ST_RESET: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == HP_CNT_W'(HP_RESET_CYC - 1)) begin
                  st_q  <= HP_ST_IDLE;
                  cnt_q <= '0;
               end
            end
            HP_ST_IDLE: begin
               if (cmd_wr || cmd_rd) begin
                  st_q    <= HP_ST_SETUP;
                  we_q    <= cmd_wr;
                  addr_q  <= cmd_addr;
                  wdata_q <= cmd_wdata;
                  cnt_q   <= '0;
               end
            end
            HP_ST_SETUP: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == HP_CNT_W'(HP_SETUP_CYC - 1)) begin
                  st_q  <= HP_ST_STROBE;
                  cnt_q <= '0;
               end
            end
            HP_ST_STROBE: begin
               if (cnt_q != HP_CNT_W'(HP_STROBE_CYC - 1)) begin
                  cnt_q <= cnt_q + 1'b1;
               end else if (lnk.host_wait_n) begin
                  st_q    <= HP_ST_HOLD;
                  cnt_q   <= '0;
                  rdata_q <= we_q ? rdata_q : lnk.host_data_bus;
               end
            end
            HP_ST_HOLD: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == HP_CNT_W'(HP_HOLD_CYC - 1)) begin
                  st_q   <= HP_ST_IDLE;
                  cnt_q  <= '0;
                  done_q <= 1'b1;
               end
            end
            default: st_q <= HP_ST_RESET;
         endcase
      end
   end

   // interrupt pins are taken as synchronous levels
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_q  <= 1'b0;
         sirq_q <= 1'b0;
      end else begin
         irq_q  <= ~lnk.decoder_irq_n;
         sirq_q <= ~lnk.scsi_irq_n;
      end
   end

   assign sel    = (st_q == HP_ST_SETUP) || (st_q == HP_ST_STROBE) ||
                   (st_q == HP_ST_HOLD);
   assign strobe = (st_q == HP_ST_STROBE);

   assign lnk.select_polarity_pin = SEL_ACTIVE_LOW;
   assign lnk.host_select    = SEL_ACTIVE_LOW ? ~sel : sel;
   assign lnk.host_read_n    = ~(strobe & ~we_q);
   assign lnk.host_write_n   = ~(strobe & we_q);
   assign lnk.reg_select_bus = addr_q;
   assign lnk.chip_reset_n   = (st_q != HP_ST_RESET);
   assign lnk.host_data_h_o  = wdata_q;
   assign lnk.host_data_h_oe = sel & we_q;

   assign cmd_busy   = (st_q != HP_ST_IDLE);
   assign cmd_done   = done_q;
   assign cmd_rdata  = rdata_q;
   assign chip_ready = (st_q != HP_ST_RESET);
   assign dec_irq    = irq_q;
   assign scsi_irq   = sirq_q;
endmodule

// *** tb/hp_link_monitor.sv ***
// concurrent checks on the pins between host end and device end
`timescale 1ns/1ns
module hp_link_monitor
   import hp_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // link pins
   input  wire logic       host_select,
   input  wire logic       select_polarity_pin,
   input  wire logic       host_read_n,
   input  wire logic       host_write_n,
   input  wire logic [6:0] reg_select_bus,
   input  wire logic       chip_reset_n,
   input  wire logic [7:0] host_data_bus,
   input  wire logic       host_data_d_oe,
   input  wire logic       host_wait_n_oe,
   input  wire logic       decoder_irq_n_oe,
   input  wire logic       scsi_irq_n_oe
);
   logic       sel;
   logic       en_q;
   logic [8:0] low_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   assign sel = select_polarity_pin ? !host_select : host_select;
   // shadow of the scsi interrupt enable, taken from link writes
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         en_q <= 1'b0;
      else if (!chip_reset_n)
         en_q <= 1'b0;
      else if (sel && !host_write_n && reg_select_bus == HP_A_SCSI_CTRL)
         en_q <= host_data_bus[HP_B_SCSI_EN];
   end
   // cycles spent with the device held in reset
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         low_q <= '0;
      else if (!chip_reset_n && low_q != 9'h1ff)
         low_q <= low_q + 9'h1;
   end
   data_drive_a: assert property (
      host_data_d_oe == (sel && !host_read_n))
      else $error("data bus drive does not match selected read");
   strobe_excl_a: assert property (
      !(!host_read_n && !host_write_n))
      else $error("read and write strobes active together");
   read_len_a: assert property (
      $fell(host_read_n) |-> (!host_read_n)[*3])
      else $error("read strobe shorter than three cycles");
   wait_cause_a: assert property (
      host_wait_n_oe |-> sel && reg_select_bus == HP_A_BUF_DATA
         && !(host_read_n && host_write_n))
      else $error("wait asserted outside a buffer access");
   wait_start_a: assert property (
      sel && !host_read_n && $past(host_read_n)
         && reg_select_bus == HP_A_BUF_DATA |-> host_wait_n_oe)
      else $error("buffer read started without wait");
   wait_hold_a: assert property (
      host_wait_n_oe && !host_read_n |=> !host_read_n)
      else $error("host ended read while wait was low");
   reset_quiet_a: assert property (
      (!chip_reset_n)[*2] |-> !decoder_irq_n_oe && !scsi_irq_n_oe
         && !host_wait_n_oe)
      else $error("device pulls a pin low while in reset");
   reset_len_a: assert property (
      $rose(chip_reset_n) |-> low_q >= 9'(HP_RESET_CYC - 1))
      else $error("device reset released too early");
   scsi_gate_a: assert property (
      (!en_q)[*3] |-> !scsi_irq_n_oe)
      else $error("scsi interrupt driven while disabled");
endmodule

// *** tb/testbench.sv ***
// self-checking bench for both ends of the host register link
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
   tests_run++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
   end \
end
module testbench
   import hp_pkg::*;
;
   localparam logic [6:0] RA [3] = '{HP_A_DEC_MASK, HP_A_SCSI_CTRL,
                                     HP_A_CLK_CFG};
   localparam logic [7:0] RM [3] = '{8'hff, 8'h8f, 8'h07};
   // config, aux select, expected mck, decoder and scsi ticks per 60
   localparam int         CT [4][5] = '{'{0, 0, 30, 30, 30},
      '{1, 1, 15, 30, 10}, '{2, 0, 0, 30, 30}, '{4, 1, 30, 15, 10}};
   logic       ref_clk, rst_b, main_osc_in, aux_osc_in, aux_osc_select;
   logic       cmd_wr, cmd_rd, cmd_busy, cmd_done, chip_ready, dec_irq;
   logic       scsi_irq, dec_irq2, master_clock_out, dec_clk_tick, pm;
   logic       scsi_clk_tick, buf_req, buf_we, buf_ack, we_seen, pd, ps;
   logic [6:0] cmd_addr;
   logic [7:0] cmd_wdata, cmd_rdata, rdata2, buf_wdata, buf_rdata;
   logic [7:0] dec_event, v, m, wd_seen, bval;
   logic [3:0] scsi_event_tgl;
   int         n_errors, tests_run, seed, bdly, i, k, aux_n, cm, cd, cs;
   hp_link_if lnk ();
   hp_link_if lnk2 ();
   hp_dev_end hp_dev_end_inst (.ref_clk, .rst_b, .lnk(lnk.dev),
      .main_osc_in, .aux_osc_in, .aux_osc_select, .master_clock_out,
      .dec_clk_tick, .scsi_clk_tick, .dec_event, .scsi_event_tgl,
      .buf_req, .buf_we, .buf_wdata, .buf_ack, .buf_rdata);
   hp_host_end hp_host_end_inst (.ref_clk, .rst_b, .lnk(lnk.host),
      .cmd_addr, .cmd_wdata, .cmd_wr, .cmd_rd, .cmd_busy, .cmd_done,
      .cmd_rdata, .chip_ready, .dec_irq, .scsi_irq);
   // second pair with an active-high select, fed the same traffic
   hp_dev_end hp_dev_end_inst2 (.ref_clk, .rst_b, .lnk(lnk2.dev),
      .main_osc_in, .aux_osc_in, .aux_osc_select, .master_clock_out(),
      .dec_clk_tick(), .scsi_clk_tick(), .dec_event, .scsi_event_tgl,
      .buf_req(), .buf_we(), .buf_wdata(), .buf_ack, .buf_rdata);
   hp_host_end #(.SEL_ACTIVE_LOW(1'b0)) hp_host_end_inst2 (.ref_clk,
      .rst_b, .lnk(lnk2.host), .cmd_addr, .cmd_wdata, .cmd_wr, .cmd_rd,
      .cmd_busy(), .cmd_done(), .cmd_rdata(rdata2), .chip_ready(),
      .dec_irq(dec_irq2), .scsi_irq());
   hp_link_monitor hp_link_monitor_inst (.ref_clk, .rst_b,
      .host_select(lnk.host_select), .host_read_n(lnk.host_read_n),
      .select_polarity_pin(lnk.select_polarity_pin),
      .host_write_n(lnk.host_write_n), .reg_select_bus(lnk.reg_select_bus),
      .chip_reset_n(lnk.chip_reset_n), .host_data_bus(lnk.host_data_bus),
      .host_data_d_oe(lnk.host_data_d_oe), .host_wait_n_oe(lnk.host_wait_n_oe),
      .decoder_irq_n_oe(lnk.decoder_irq_n_oe),
      .scsi_irq_n_oe(lnk.scsi_irq_n_oe));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // oscillators: main toggles every cycle, aux every third cycle
   always @(posedge ref_clk) begin
      main_osc_in <= ~main_osc_in;
      aux_n <= (aux_n == 2) ? 0 : aux_n + 1;
      if (aux_n == 2)
         aux_osc_in <= ~aux_osc_in;
   end
   // buffer ram answers after bdly cycles
   always @(posedge ref_clk) begin
      buf_ack <= 1'b0;
      if (buf_req && !buf_ack) begin
         if (bdly == 0) begin
            buf_ack <= 1'b1;
            buf_rdata <= bval;
            we_seen <= buf_we;
            wd_seen <= buf_wdata;
         end else
            bdly <= bdly - 1;
      end
   end
   function automatic logic near(int c, int e);
      return (c >= e - 1) && (c <= e + 1);
   endfunction
   task automatic cmd(input logic w, input logic [6:0] a,
                      input logic [7:0] d);
      @(posedge ref_clk);
      cmd_wr <= w;
      cmd_rd <= !w;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(posedge ref_clk);
      cmd_wr <= 1'b0;
      cmd_rd <= 1'b0;
      #1;
      for (i = 0; i < 100 && cmd_done !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      `CHK("done", 1'b1, cmd_done)
      if (!w)
         `CHK("pair rdata", cmd_rdata, rdata2)
   endtask
   task automatic do_reset;
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK("ready in reset", 1'b0, chip_ready)
      `CHK("irq pin in reset", 1'b1, lnk.decoder_irq_n)
      for (k = 2; k < 400 && chip_ready !== 1'b1; k++) begin
         @(posedge ref_clk);
         #1;
      end
      `CHK("reset len", 1'b1, near(k, HP_RESET_CYC) && k < 400)
      for (k = 0; k < 20 && cmd_busy !== 1'b0; k++) begin
         @(posedge ref_clk);
         #1;
      end
   endtask
   task print_verdict;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      {rst_b, cmd_wr, cmd_rd, main_osc_in, aux_osc_in, aux_osc_select} = '0;
      {cmd_addr, cmd_wdata, dec_event, scsi_event_tgl, bval} = '0;
      {n_errors, tests_run, bdly, aux_n} = '0;
      seed = 32'h2f376ae2;
      do_reset();
      `CHK("idle bus", 8'hff, lnk.host_data_bus)
      for (int r = 0; r < 3; r++) begin
         v = 8'($random(seed)) & RM[r];
         cmd(1'b1, RA[r], v);
         cmd(1'b0, RA[r], 8'h00);
         `CHK("reg readback", v, cmd_rdata)
      end
      cmd(1'b1, 7'h7f, 8'h5a);
      cmd(1'b0, 7'h7f, 8'h00);
      `CHK("unmapped read", 8'h00, cmd_rdata)
      for (int r = 0; r < 5; r++) begin
         m = (r == 0) ? 8'h00 : 8'($random(seed));
         v = (r == 4) ? 8'h80 : 8'($random(seed));
         cmd(1'b1, HP_A_DEC_MASK, m);
         @(posedge ref_clk);
         dec_event <= v;
         @(posedge ref_clk);
         dec_event <= '0;
         repeat (3) @(posedge ref_clk);
         #1;
         `CHK("dec irq pin", !(|(v & m)), lnk.decoder_irq_n)
         `CHK("dec irq pair", dec_irq, dec_irq2)
         `CHK("dec irq out", |(v & m), dec_irq)
         cmd(1'b0, HP_A_DEC_STAT, 8'h00);
         `CHK("dec status", v, cmd_rdata)
         cmd(1'b0, HP_A_DEC_STAT, 8'h00);
         `CHK("dec cleared", 8'h00, cmd_rdata)
      end
      for (int r = 0; r < 4; r++) begin
         m = {r[0], 3'h0, 4'($random(seed))};
         v = {4'h0, 4'($random(seed))};
         cmd(1'b1, HP_A_SCSI_CTRL, m);
         @(posedge ref_clk);
         scsi_event_tgl <= scsi_event_tgl ^ v[3:0];
         repeat (8) @(posedge ref_clk);
         #1;
         `CHK("scsi irq", !(m[7] && |(v & m)), lnk.scsi_irq_n)
         `CHK("scsi irq out", m[7] && |(v & m), scsi_irq)
         cmd(1'b0, HP_A_SCSI_STAT, 8'h00);
         `CHK("scsi status", v, cmd_rdata)
      end
      for (int r = 0; r < 4; r++) begin
         bdly = (r == 0) ? 0 : $unsigned($random(seed)) % 6;
         bval = 8'($random(seed));
         cmd(1'b0, HP_A_BUF_DATA, 8'h00);
         `CHK("buf read", bval, cmd_rdata)
         v = 8'($random(seed));
         bdly = r;
         cmd(1'b1, HP_A_BUF_DATA, v);
         `CHK("buf write", {1'b1, v}, {we_seen, wd_seen})
      end
      for (int r = 0; r < 4; r++) begin
         cmd(1'b1, HP_A_CLK_CFG, 8'(CT[r][0]));
         @(posedge ref_clk);
         aux_osc_select <= CT[r][1] != 0;
         repeat (8) @(posedge ref_clk);
         {cm, cd, cs, pm, pd, ps} = '0;
         repeat (60) begin
            @(posedge ref_clk);
            #1;
            cm += int'(master_clock_out && !pm);
            cd += int'(dec_clk_tick && !pd);
            cs += int'(scsi_clk_tick && !ps);
            {pm, pd, ps} = {master_clock_out, dec_clk_tick, scsi_clk_tick};
         end
         `CHK("mck rate", 1'b1, near(cm, CT[r][2]))
         `CHK("dec tick rate", 1'b1, near(cd, CT[r][3]))
         `CHK("scsi tick rate", 1'b1, near(cs, CT[r][4]))
      end
      do_reset();
      cmd(1'b0, HP_A_CLK_CFG, 8'h00);
      `CHK("cfg after reset", HP_RST_REG, cmd_rdata)
      cmd(1'b0, HP_A_DEC_MASK, 8'h00);
      `CHK("mask after reset", HP_RST_REG, cmd_rdata)
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      print_verdict();
   end
endmodule
